// ---- verilog/hide_encoder.sv ----
// Purpose: build fault, lost, group and length fields of interrupt descriptors
// Assumes: reports and parity pulses come from core_clk logic
// Notes: descriptors queue internally and are drained over APB
// Function
// - report code 9 when closed frame check sequence mismatches
// - report code 10 when payload is not whole octets
// - octet misfit suppresses the separate frame check fault
// - report code 11 when message ends with abort pattern
// - report code 12 when message exceeds maximum size
// - oversize message is stopped and its data not written
// - report code 13 when message not longer than check field
// - undersize message data is not written to memory
// - report code 14 when signal unit monitor passes threshold
// - report code 15 on received bus data parity error
// - system error signal causes no action
// - full queue drops new events and marks bit 15 of last
// - lost marking changes only the lost bit
// - group number msb goes to bit 14
// - receive buffer or message end carries received octet count
// - transmit buffer end carries targeted buffer length
// - length is zero for every other event
// - rx end pair is one descriptor, tx ends two
`timescale 1ns/1ps
`include "hide_cfg.svh"
module hide_encoder
    import hide_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire hide_report_type report,
    input wire logic report_valid,
    input wire logic parity_fault_in,
    input wire logic parity_resp_en,
    input wire logic sys_error_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic discard_data
);
    // four-entry queue; pointers wrap by their own width
    localparam int DW = $clog2(`HIDE_QDEPTH);
    logic [31:0] mem_q [`HIDE_QDEPTH];
    logic [31:0] mem_d [`HIDE_QDEPTH];
    logic [DW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [DW:0] cnt_q, cnt_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, discard_d;
    logic soft_rst_q, soft_rst_d;
    logic [3:0] fault;
    logic [31:0] desc_a, desc_b, desc_p;
    logic [1:0] n_new;
    logic apb_acc, pop;
    ////////////////////////////////////////////////////////////////////////
    // fault selection, octet misfit (code 10) first, then the other codes lowest first
    always_comb begin
        fault = `HIDE_FAULT_NONE;
        if (report.octet_misfit) begin
            fault = `HIDE_FAULT_ALIGN;
        end else if (report.fcs_bad) begin
            fault = `HIDE_FAULT_FCS;
        end else if (report.abort_end) begin
            fault = `HIDE_FAULT_ABORT;
        end else if (report.oversize_msg) begin
            fault = `HIDE_FAULT_LONG;
        end else if (report.undersize_msg) begin
            fault = `HIDE_FAULT_SHORT;
        end else if (report.signal_unit_rate_alarm) begin
            fault = `HIDE_FAULT_SIGNAL_UNIT_RATE_ALARM;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // descriptor assembly for the incoming report
    always_comb begin
        desc_a = 32'h0000_0000;
        desc_a[`HIDE_FAULT_LSB +: 4] = fault;
        desc_a[`HIDE_GRP_BIT] = report.group[2];
        if (report.evt == HIDE_EV_RX_EOB || report.evt == HIDE_EV_RX_EOM ||
            report.evt == HIDE_EV_TX_EOB) begin
            desc_a[13:0] = report.byte_length;
        end
        // tx ends split into second descriptor without length
        desc_b = desc_a;
        desc_b[13:0] = 14'h0000;
        // parity fault has its own descriptor, no group or length
        desc_p = 32'h0000_0000;
        desc_p[`HIDE_FAULT_LSB +: 4] = `HIDE_FAULT_PARITY;
        n_new = 2'd0;
        if (report_valid && report.evt != HIDE_EV_NONE) begin
            n_new = (report.evt == HIDE_EV_TX_EOB && report.both_eob_eom) ? 2'd2 : 2'd1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // apb decode: one wait state, answer on the cycle after access opens
    // sys_error_n is deliberately left unused by every path
    assign apb_acc = psel && penable;
    // pop only on the first access cycle, so an access pops at most once
    assign pop = apb_acc && !pready && !pwrite && paddr == `HIDE_ADDR_POP && cnt_q != '0;
    // writes to the read-only offsets are accepted and ignored
    always_comb begin
        soft_rst_d = 1'b0;
        prdata_d = 32'h0000_0000;
        pready_d = apb_acc && !pready;
        pslverr_d = 1'b0;
        if (apb_acc && !pready) begin
            if (paddr == `HIDE_ADDR_CTRL) begin
                soft_rst_d = pwrite && pwdata[0];
            end else if (paddr == `HIDE_ADDR_STAT) begin
                prdata_d = {{(31-DW){1'b0}}, cnt_q};
            end else if (paddr == `HIDE_ADDR_DESC || paddr == `HIDE_ADDR_POP) begin
                // an empty queue reads as zero rather than a stale entry
                prdata_d = (cnt_q != '0) ? mem_q[rp_q] : 32'h0000_0000;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end
    // apb answer registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            soft_rst_q <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            soft_rst_q <= soft_rst_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // queue fill, drain and lost marking
    always_comb begin
        logic [DW:0] c;
        logic [DW-1:0] w;
        logic par;
        c = cnt_q;
        w = wp_q;
        par = parity_fault_in && parity_resp_en;
        mem_d = mem_q;
        rp_d = rp_q;
        // oversize or undersize data never goes to memory
        discard_d = report_valid && (report.oversize_msg || report.undersize_msg);
        // a pop frees its slot before new reports claim one
        if (pop) begin
            rp_d = rp_q + 1'b1;
            c = c - 1'b1;
        end
        // slots 0 and 1 carry the report, slot 2 a parity fault
        for (int k = 0; k < 3; k++) begin
            if ((k < 2 && k < int'(n_new)) || (k == 2 && par)) begin
                if (c < (DW+1)'(`HIDE_QDEPTH)) begin
                    if (k == 0) begin
                        mem_d[w] = desc_a;
                    end else if (k == 1) begin
                        mem_d[w] = desc_b;
                    end else begin
                        mem_d[w] = desc_p;
                    end
                    w = w + 1'b1;
                    c = c + 1'b1;
                end else begin
                    // drop new one, flag only bit 15 of newest queued
                    mem_d[w - 1'b1][`HIDE_LOST_BIT] = 1'b1;
                end
            end
        end
        // pointers wrap naturally at the queue depth
        wp_d = w;
        cnt_d = c;
        // soft reset drops the count; stale entries are never read again
        if (soft_rst_q) begin
            wp_d = '0;
            rp_d = '0;
            cnt_d = '0;
        end
    end
    // queue registers, reset clears every slot
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < `HIDE_QDEPTH; i++) begin
                mem_q[i] <= 32'h0000_0000;
            end
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            discard_data <= 1'b0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            discard_data <= discard_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // checks
    // fault selection: one code per descriptor, misfit first
    misfit_over_fcs_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report.octet_misfit |-> fault == `HIDE_FAULT_ALIGN)
        else $error("misfit not chosen over check fault");
    abort_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !report.octet_misfit && !report.fcs_bad && report.abort_end
        |-> fault == `HIDE_FAULT_ABORT)
        else $error("abort code wrong");
    fcs_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !report.octet_misfit && report.fcs_bad |-> desc_a[19:16] == `HIDE_FAULT_FCS)
        else $error("check fault code wrong");
    // with no fault flag the fault field stays clear
    fault_none_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !report.octet_misfit && !report.fcs_bad && !report.abort_end && !report.oversize_msg
        && !report.undersize_msg && !report.signal_unit_rate_alarm
        |-> desc_a[19:16] == `HIDE_FAULT_NONE)
        else $error("fault field not clear");
    // group msb rides on both descriptors of a pair
    group_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
        desc_a[`HIDE_GRP_BIT] == report.group[2])
        else $error("group msb misplaced");
    group_pair_a: assert property (@(posedge core_clk) disable iff (!nrst)
        desc_b[`HIDE_GRP_BIT] == report.group[2])
        else $error("group msb missing on second descriptor");
    // length field only for rx buffer or message ends and tx buffer end
    length_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report.evt inside {HIDE_EV_NONE, HIDE_EV_TX_EOM, HIDE_EV_ERROR}
        |-> desc_a[13:0] == 14'h0000)
        else $error("length not zero");
    rx_length_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report.evt == HIDE_EV_RX_EOM |-> desc_a[13:0] == report.byte_length)
        else $error("rx length wrong");
    tx_length_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report.evt == HIDE_EV_TX_EOB |-> desc_a[13:0] == report.byte_length)
        else $error("tx buffer length wrong");
    // discard pulse follows every dropped message by one cycle
    discard_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.oversize_msg |=> discard_data)
        else $error("oversize data not discarded");
    undersize_drop_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.undersize_msg |=> discard_data)
        else $error("undersize data not discarded");
    // pairs: tx end pair takes two slots, rx end pair one
    tx_pair_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.evt == HIDE_EV_TX_EOB && report.both_eob_eom && cnt_q < 3'd3
        && !pop && !soft_rst_q && !(parity_fault_in && parity_resp_en)
        |=> cnt_q == $past(cnt_q) + 3'd2)
        else $error("tx end pair not two descriptors");
    rx_pair_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.evt == HIDE_EV_RX_EOM && report.both_eob_eom && cnt_q < 3'd4
        && !pop && !soft_rst_q && !(parity_fault_in && parity_resp_en)
        |=> cnt_q == $past(cnt_q) + 3'd1)
        else $error("rx end pair not one descriptor");
    // overflow: newest queued entry gets the lost bit and nothing else changes
    lost_mark_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.evt == HIDE_EV_RX_EOM && cnt_q == 3'd4 && !pop
        && !soft_rst_q |=> mem_q[$past(wp_q) - 1'b1][`HIDE_LOST_BIT] && cnt_q == 3'd4)
        else $error("lost flag not set");
    lost_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
        report_valid && report.evt != HIDE_EV_NONE && cnt_q == 3'd4 && !pop && !soft_rst_q
        |=> (mem_q[$past(wp_q) - 1'b1] & 32'hffff_7fff)
        == ($past(mem_q[wp_q - 1'b1]) & 32'hffff_7fff))
        else $error("lost marking touched other bits");
    // parity: an unmasked fault lands in the queue, a masked one does not
    parity_code_a: assert property (@(posedge core_clk) disable iff (!nrst)
        parity_fault_in && parity_resp_en && !report_valid && cnt_q == 3'd0 && !soft_rst_q
        |=> mem_q[$past(wp_q)][19:16] == `HIDE_FAULT_PARITY)
        else $error("parity code wrong");
    parity_mask_a: assert property (@(posedge core_clk) disable iff (!nrst)
        parity_fault_in && !parity_resp_en && !report_valid && !pop && !soft_rst_q
        |=> cnt_q == $past(cnt_q))
        else $error("masked parity fault queued");
    // bus answer: pready lasts one cycle, error and data only beside it
    ready_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
        pready |=> !pready)
        else $error("ready held too long");
    err_with_ready_a: assert property (@(posedge core_clk) disable iff (!nrst)
        pslverr |-> pready)
        else $error("error without ready");
    read_idle_a: assert property (@(posedge core_clk) disable iff (!nrst)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside answer");
    // main scenarios
    full_cov: cover property (@(posedge core_clk) cnt_q == 3'd4);
    tx_pair_cov: cover property (@(posedge core_clk) n_new == 2'd2);
    pop_cov: cover property (@(posedge core_clk) pop);
    lost_cov: cover property (@(posedge core_clk) report_valid && cnt_q == 3'd4 && !pop);
    parity_cov: cover property (@(posedge core_clk) parity_fault_in && parity_resp_en);
endmodule

// ---- pkg/hide_cfg.svh ----
// Purpose: constants for the interrupt descriptor encoder
// Assumes: 32-bit descriptors, APB register access
// Notes: offsets are byte addresses
`ifndef HIDE_CFG_SVH
`define HIDE_CFG_SVH
`define HIDE_FAULT_FCS 4'h9
`define HIDE_FAULT_ALIGN 4'ha
`define HIDE_FAULT_ABORT 4'hb
`define HIDE_FAULT_LONG 4'hc
`define HIDE_FAULT_SHORT 4'hd
`define HIDE_FAULT_SIGNAL_UNIT_RATE_ALARM 4'he
`define HIDE_FAULT_PARITY 4'hf
`define HIDE_FAULT_NONE 4'h0
`define HIDE_FAULT_LSB 16
`define HIDE_LOST_BIT 15
`define HIDE_GRP_BIT 14
`define HIDE_QDEPTH 4
`define HIDE_ADDR_CTRL 12'h000
`define HIDE_ADDR_STAT 12'h004
`define HIDE_ADDR_DESC 12'h008
`define HIDE_ADDR_POP 12'h00c
`define HIDE_CTRL_RESET 32'h0000_0001
`endif

// ---- pkg/hide_pkg.sv ----
// Purpose: types for the interrupt descriptor encoder
// Assumes: nothing beyond the config header
// Notes: event codes are local to this block
package hide_pkg;
    typedef enum logic [2:0] {
        HIDE_EV_NONE = 3'h0,
        HIDE_EV_RX_EOB = 3'h1,
        HIDE_EV_RX_EOM = 3'h2,
        HIDE_EV_TX_EOB = 3'h3,
        HIDE_EV_TX_EOM = 3'h4,
        HIDE_EV_ERROR = 3'h5
    } hide_event_type;
    // one receive or transmit event report from the channel engine
    typedef struct packed {
        hide_event_type evt;
        logic both_eob_eom;
        logic [2:0] group;
        logic [13:0] byte_length;
        logic fcs_bad;
        logic octet_misfit;
        logic abort_end;
        logic oversize_msg;
        logic undersize_msg;
        logic signal_unit_rate_alarm;
    } hide_report_type;
endpackage

// ---- sim/hide_host_model.sv ----
// Purpose: host side model that drains the descriptor queue over APB
// Assumes: slave answers with pready within 50 access cycles, at most 49 wait states
// Notes: ok stays low when no answer comes within the wait bound
`timescale 1ns/1ps
module hide_host_model (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // setup then access, held until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err, output bit ok);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        ok = (pready === 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // let an edge pass so a following call never re-drives in the same step
        @(posedge core_clk);
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the descriptor encoder
// Assumes: queue is popped oldest first at the pop offset
// Notes: only descriptor bits 19:0 are compared; event and channel fields are not built here
`timescale 1ns/1ps
`include "hide_cfg.svh"
module tb_top
    import hide_pkg::*;
;
    logic core_clk, nrst, report_valid, parity_fault_in, parity_resp_en, sys_error_n;
    logic psel, penable, pwrite, pready, pslverr, discard_data, err, seen;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    hide_report_type report;
    bit ok;
    int errors, checked;
    logic [3:0] codes [6] = '{`HIDE_FAULT_FCS, `HIDE_FAULT_ALIGN, `HIDE_FAULT_ABORT,
        `HIDE_FAULT_LONG, `HIDE_FAULT_SHORT, `HIDE_FAULT_SIGNAL_UNIT_RATE_ALARM};
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    hide_encoder dut_u (.core_clk(core_clk), .nrst(nrst), .report(report),
        .report_valid(report_valid), .parity_fault_in(parity_fault_in),
        .parity_resp_en(parity_resp_en), .sys_error_n(sys_error_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .discard_data(discard_data));
    hide_host_model host_u (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        if (errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic good, input string msg);
        checked++;
        if (good !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // a hung bus ends the run at once
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        host_u.xfer(wr, a, wd, rd, err, ok);
        if (!ok) begin
            errors++;
            $display("BAD %0t bus timeout", $time);
            report_and_stop();
        end
    endtask
    task automatic pop(input logic [19:0] exp, input string msg);
        bus(1'b0, `HIDE_ADDR_POP, 32'h0000_0000);
        chk(rd[19:0] === exp && err === 1'b0, msg);
    endtask
    function automatic hide_report_type mk(hide_event_type e, logic b, logic [2:0] g,
        logic [13:0] l, logic [5:0] f);
        return {e, b, g, l, f};
    endfunction
    // one report, then three edges watching for a discard pulse
    task automatic send(input hide_report_type r);
        report <= r;
        report_valid <= 1'b1;
        @(posedge core_clk);
        report_valid <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            @(posedge core_clk);
            seen = seen | (discard_data === 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        report = '0;
        report_valid = 1'b0;
        parity_fault_in = 1'b0;
        parity_resp_en = 1'b1;
        sys_error_n = 1'b1;
        errors = 0;
        checked = 0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        // each fault flag alone on a non-length event, group msb set
        for (int i = 0; i < 6; i++) begin
            send(mk(HIDE_EV_ERROR, 1'b0, 3'h4, 14'h0123, 6'(6'h20 >> i)));
            chk(seen === (i == 3 || i == 4), "discard pulse");
            pop({codes[i], 2'b01, 14'h0000}, "fault code");
        end
        send(mk(HIDE_EV_ERROR, 1'b0, 3'h0, 14'h0000, 6'h30));
        pop({`HIDE_FAULT_ALIGN, 16'h0000}, "misfit over check");
        send(mk(HIDE_EV_RX_EOM, 1'b1, 3'h3, 14'h1abc, 6'h00));
        send(mk(HIDE_EV_TX_EOB, 1'b1, 3'h7, 14'h0456, 6'h00));
        send(mk(HIDE_EV_TX_EOM, 1'b0, 3'h0, 14'h0789, 6'h00));
        pop({4'h0, 2'b00, 14'h1abc}, "rx length");
        pop({4'h0, 2'b01, 14'h0456}, "tx buffer length");
        pop({4'h0, 2'b01, 14'h0000}, "tx end pair");
        pop({4'h0, 2'b00, 14'h0000}, "tx end length");
        // parity fault, then a masked one while system error is active
        sys_error_n <= 1'b0;
        parity_fault_in <= 1'b1;
        @(posedge core_clk);
        parity_fault_in <= 1'b0;
        // host clears its parity response bit
        parity_resp_en <= 1'b0;
        @(posedge core_clk);
        parity_fault_in <= 1'b1;
        @(posedge core_clk);
        parity_fault_in <= 1'b0;
        sys_error_n <= 1'b1;
        send(mk(HIDE_EV_RX_EOB, 1'b0, 3'h5, 14'h0042, 6'h00));
        pop({`HIDE_FAULT_PARITY, 16'h0000}, "parity fault");
        pop({4'h0, 2'b01, 14'h0042}, "masked parity");
        // five reports back to back into a four-deep queue
        report_valid <= 1'b1;
        for (int k = 1; k < 6; k++) begin
            report <= mk(HIDE_EV_RX_EOM, 1'b0, 3'h0, 14'(k), 6'h00);
            @(posedge core_clk);
        end
        report_valid <= 1'b0;
        @(posedge core_clk);
        for (int k = 1; k < 5; k++)
            pop({4'h0, 1'(k == 4), 1'b0, 14'(k)}, "lost marking");
        // soft reset empties the queue; unmapped read is refused
        send(mk(HIDE_EV_RX_EOM, 1'b0, 3'h0, 14'h0011, 6'h00));
        bus(1'b1, `HIDE_ADDR_CTRL, `HIDE_CTRL_RESET);
        bus(1'b1, `HIDE_ADDR_CTRL, 32'h0000_0000);
        bus(1'b0, `HIDE_ADDR_STAT, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && err === 1'b0, "count after soft reset");
        send(mk(HIDE_EV_RX_EOM, 1'b0, 3'h0, 14'h0022, 6'h00));
        bus(1'b0, `HIDE_ADDR_STAT, 32'h0000_0000);
        chk(rd === 32'h0000_0001, "queue count");
        bus(1'b0, `HIDE_ADDR_DESC, 32'h0000_0000);
        chk(rd[19:0] === {4'h0, 2'b00, 14'h0022}, "peek oldest");
        pop({4'h0, 2'b00, 14'h0022}, "soft reset");
        bus(1'b0, 12'h010, 32'h0000_0000);
        chk(err === 1'b1, "unmapped address");
        report_and_stop();
    end
endmodule
